// file: cpu_bus_pins.sv
// processor bus pin driver: strobes, address, data and direction control
// assumes core requests on clk_in; pins from outside pass two flip-flops
`timescale 1ns/10ps
module cpu_bus_pins
    import cpu_bus_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic emulation_mode_in,
    input wire logic ext_master_in,
    input wire logic cycle_start_in,
    input wire cycle_kind_t cycle_kind_in,
    input wire logic [15:0] cycle_addr_in,
    input wire logic [7:0] write_data_in,
    input wire logic [7:0] refresh_addr_in,
    input wire logic internal_target_in,
    input wire logic [7:0] periph_read_data_in,
    output logic cycle_done_out,
    output logic [7:0] read_data_out,
    input wire logic [15:0] addr_pin_in,
    output logic [15:0] addr_pin_out,
    output logic addr_pin_oe_out,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic data_pin_oe_out,
    input wire logic load_strobe_n_in,
    output logic load_strobe_n_out,
    input wire logic write_strobe_n_in,
    output logic write_strobe_n_out,
    input wire logic memory_cycle_strobe_n_in,
    output logic memory_cycle_strobe_n_out,
    input wire logic port_cycle_strobe_n_in,
    output logic port_cycle_strobe_n_out,
    output logic strobe_oe_out,
    output logic opcode_fetch_cycle_n_out,
    output logic opcode_fetch_cycle_n_oe_out,
    output logic ext_access_out,
    output logic [15:0] ext_addr_out,
    output logic [7:0] ext_write_data_out,
    output logic ext_read_out,
    output logic ext_write_out
);
    typedef struct packed
    {
        bus_state_t state;
        logic [1:0] phase;
        logic reading;
        logic internal;
        logic fetch;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic [1:0] ext_sync;
        logic [1:0] emu_sync;
        logic [1:0] rd_sync;
        logic [1:0] wr_sync;
        logic [1:0] memory_cycle_strobe_n_sync;
        logic [1:0] port_cycle_strobe_n_sync;
        logic [15:0] ext_addr_s1;
        logic [15:0] ext_addr;
        logic [7:0] ext_data_s1;
        logic [7:0] ext_data;
        logic [7:0] ext_rdata;
        logic wr_seen;
        logic ext_wr_pulse;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic ext_mode;
    logic ext_rd;
    logic ext_wr;

    assign ext_mode = cur.ext_sync[1];
    // port strobe low with load or write strobe low: an external peripheral access
    assign ext_rd = ext_mode && !cur.rd_sync[1] && !cur.port_cycle_strobe_n_sync[1];
    assign ext_wr = ext_mode && !cur.wr_sync[1] && !cur.port_cycle_strobe_n_sync[1];

    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.ext_wr_pulse = 1'b0;
        next_cur.ext_sync = {cur.ext_sync[0], ext_master_in};
        next_cur.emu_sync = {cur.emu_sync[0], emulation_mode_in};
        next_cur.rd_sync = {cur.rd_sync[0], load_strobe_n_in};
        next_cur.wr_sync = {cur.wr_sync[0], write_strobe_n_in};
        next_cur.memory_cycle_strobe_n_sync = {cur.memory_cycle_strobe_n_sync[0], memory_cycle_strobe_n_in};
        next_cur.port_cycle_strobe_n_sync = {cur.port_cycle_strobe_n_sync[0], port_cycle_strobe_n_in};
        next_cur.ext_addr_s1 = addr_pin_in;
        next_cur.ext_addr = cur.ext_addr_s1;
        next_cur.ext_data_s1 = data_pin_in;
        next_cur.ext_data = cur.ext_data_s1;
        next_cur.ext_rdata = periph_read_data_in;
        next_cur.wr_seen = ext_wr;
        if (ext_wr && !cur.wr_seen)
        begin
            next_cur.ext_wr_pulse = 1'b1;
        end
        case (cur.state)
            st_idle:
            begin
                // no new cycles while the external master owns the bus
                if (cycle_start_in && !ext_mode)
                begin
                    next_cur.phase = 2'h0;
                    next_cur.addr = cycle_addr_in;
                    next_cur.wdata = write_data_in;
                    next_cur.internal = internal_target_in;
                    next_cur.fetch = 1'b0;
                    next_cur.reading = 1'b1;
                    case (cycle_kind_in)
                        cyc_fetch:
                        begin
                            next_cur.fetch = 1'b1;
                            next_cur.state = st_memory;
                        end
                        cyc_mem_read: next_cur.state = st_memory;
                        cyc_mem_write:
                        begin
                            next_cur.reading = 1'b0;
                            next_cur.state = st_memory;
                        end
                        cyc_port_read: next_cur.state = st_port;
                        cyc_port_write:
                        begin
                            next_cur.reading = 1'b0;
                            next_cur.state = st_port;
                        end
                        cyc_int_ack:
                        begin
                            next_cur.fetch = 1'b1;
                            next_cur.internal = 1'b0;
                            next_cur.state = st_ack;
                        end
                        cyc_refresh:
                        begin
                            next_cur.reading = 1'b0;
                            next_cur.addr = {cycle_addr_in[15:8],
                                refresh_addr_in};
                            next_cur.state = st_refresh;
                        end
                        default: next_cur.state = st_idle;
                    endcase
                end
            end
            st_memory, st_port, st_ack, st_refresh:
            begin
                next_cur.phase = cur.phase + 2'h1;
                // data sampled on the last phase, strobes still active;
                // ack runs one phase longer: the vector only appears once
                // the port strobe is low, and needs two flops to arrive
                if ((cur.phase == 2'h2 && cur.state != st_ack)
                    || cur.phase == 2'h3)
                begin
                    next_cur.rdata = cur.internal ? periph_read_data_in
                        : cur.ext_data;
                    next_cur.done = 1'b1;
                    next_cur.state = st_idle;
                    next_cur.fetch = 1'b0;
                end
            end
            default: next_cur.state = st_idle;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cur <= '{state: st_idle, default: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    always_comb
    begin
        addr_pin_out = cur.addr;
        addr_pin_oe_out = !ext_mode;
        strobe_oe_out = !ext_mode;
        // a refresh cycle only sets the low byte; high byte follows caller
        memory_cycle_strobe_n_out = !(cur.state == st_memory
            || cur.state == st_refresh);
        port_cycle_strobe_n_out = !((cur.state == st_port)
            || (cur.state == st_ack && cur.phase != 2'h0));
        load_strobe_n_out = !(cur.reading && (cur.state == st_memory
            || cur.state == st_port));
        write_strobe_n_out = !(!cur.reading && cur.phase != 2'h0
            && (cur.state == st_memory || cur.state == st_port));
        opcode_fetch_cycle_n_out = !cur.fetch;
        opcode_fetch_cycle_n_oe_out = !cur.emu_sync[1];
        data_pin_out = cur.wdata;
        data_pin_oe_out = 1'b0;
        if (ext_mode)
        begin
            data_pin_out = cur.ext_rdata;
            data_pin_oe_out = ext_rd;
        end
        else if (cur.state == st_memory || cur.state == st_port)
        begin
            if (cur.internal)
            begin
                // internal transfers are mirrored on the pins both ways
                data_pin_out = cur.reading ? periph_read_data_in
                    : cur.wdata;
                data_pin_oe_out = 1'b1;
            end
            else
            begin
                data_pin_oe_out = !cur.reading;
            end
        end
        cycle_done_out = cur.done;
        read_data_out = cur.rdata;
        ext_access_out = ext_mode;
        ext_addr_out = cur.ext_addr;
        ext_write_data_out = cur.ext_data;
        ext_read_out = ext_rd;
        ext_write_out = cur.ext_wr_pulse;
    end
endmodule

// file: cpu_bus_pkg.sv
// constants for the processor-side bus pin control block
// assumes a single 20 mhz system clock domain
package cpu_bus_pkg;
    localparam int addr_width = 16;
    localparam int data_width = 8;
    localparam int port_addr_width = 8;
    localparam logic [15:0] addr_reset = 16'h0000;
    localparam logic [7:0] data_reset = 8'h00;
    localparam logic strobe_idle = 1'b1;
    typedef enum logic [4:0]
    {
        st_idle = 5'b00001,
        st_memory = 5'b00010,
        st_port = 5'b00100,
        st_ack = 5'b01000,
        st_refresh = 5'b10000
    } bus_state_t;
    typedef enum logic [2:0]
    {
        cyc_none = 3'h0,
        cyc_fetch = 3'h1,
        cyc_mem_read = 3'h2,
        cyc_mem_write = 3'h3,
        cyc_port_read = 3'h4,
        cyc_port_write = 3'h5,
        cyc_int_ack = 3'h6,
        cyc_refresh = 3'h7
    } cycle_kind_t;
endpackage

// file: cpu_bus_chk.sv
// checker: strobe, direction and fetch timing of the bus pins
// assumes it is bound to cpu_bus_pins on one clock
`timescale 1ns/10ps
module cpu_bus_chk(
    input wire logic clk_in, rst_in, emulation_mode_in, cycle_done_out,
    input wire logic addr_pin_oe_out, data_pin_oe_out, strobe_oe_out,
    input wire logic load_strobe_n_out, write_strobe_n_out,
    input wire logic memory_cycle_strobe_n_out, port_cycle_strobe_n_out,
    input wire logic ext_access_out, opcode_fetch_cycle_n_out,
    input wire logic opcode_fetch_cycle_n_oe_out, load_strobe_n_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic m, p, f;
    assign m = !memory_cycle_strobe_n_out && strobe_oe_out;
    assign p = !port_cycle_strobe_n_out && strobe_oe_out;
    assign f = !opcode_fetch_cycle_n_out;
    mem_addr_a: assert property (m |-> addr_pin_oe_out && !p)
        else $error("memory strobe without address");
    port_addr_a: assert property (p |-> addr_pin_oe_out && !m)
        else $error("port strobe without address");
    ext_float_a: assert property (ext_access_out |-> !addr_pin_oe_out
        && !strobe_oe_out) else $error("pins driven under master");
    write_data_a: assert property (!write_strobe_n_out && strobe_oe_out
        |-> data_pin_oe_out && load_strobe_n_out) else $error("write data");
    read_src_a: assert property ($fell(load_strobe_n_out)
        && strobe_oe_out |-> m || p) else $error("read without request");
    ack_order_a: assert property (p && f |-> $past(f) && load_strobe_n_out)
        else $error("acknowledge order");
    fetch_span_a: assert property ($rose(f) && m |-> f[*3]
        ##1 (!f && cycle_done_out)) else $error("fetch span");
    ack_span_a: assert property ($rose(f) && !m |-> f[*4]
        ##1 (!f && cycle_done_out)) else $error("acknowledge span");
    ext_drive_a: assert property (ext_access_out && data_pin_oe_out
        |-> !$past(load_strobe_n_in, 2))
        else $error("data driven without external read");
    emu_float_a: assert property (emulation_mode_in[*3] |->
        !opcode_fetch_cycle_n_oe_out) else $error("fetch not floated");
endmodule
bind cpu_bus_pins cpu_bus_chk chk (.*);

// file: ext_dev.sv
// partner: external memory and port devices on the data bus
// assumes resolved active-low strobes; the block wins the bus
`timescale 1ns/10ps
module ext_dev(
    input wire logic clk_in, oe_in, rd_n_in, mem_n_in, port_n_in, fetch_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] dout_in,
    output logic [7:0] bus_out
);
    logic [7:0] last = 8'h00;
    always_comb
    begin
        if (oe_in)
            bus_out = dout_in;
        else if (!port_n_in && !fetch_n_in)
            bus_out = 8'h3c;
        else if (!rd_n_in && !(mem_n_in && port_n_in))
            bus_out = addr_in[7:0] ^ 8'h5a;
        else
            bus_out = ~last; // released bus keeps no value
    end
    always_ff @(posedge clk_in) last <= bus_out;
endmodule

// file: tb_top.sv
// testbench: every cycle kind, emulation float, external master
// assumes cpu_bus_pins with its checker bound
`timescale 1ns/10ps
module tb_top;
    import cpu_bus_pkg::*;
    logic clk_in = 0, rst_in = 1, emulation_mode_in = 0, m_rd = 1, m_port = 1;
    logic ext_master_in = 0, cycle_start_in = 0, internal_target_in = 0;
    logic m_wr = 1;
    logic [7:0] m_d = 8'hc3, dev_bus;
    cycle_kind_t cycle_kind_in = cyc_none;
    logic [15:0] cycle_addr_in = 16'h8133, m_a = 16'h0042;
    logic [7:0] write_data_in = 8'ha5, refresh_addr_in = 8'h7e;
    logic [7:0] periph_read_data_in = 8'h96, data_pin_in, data_pin_out;
    logic load_strobe_n_in, write_strobe_n_in, memory_cycle_strobe_n_in;
    logic port_cycle_strobe_n_in, cycle_done_out, addr_pin_oe_out;
    logic data_pin_oe_out, load_strobe_n_out, write_strobe_n_out;
    logic memory_cycle_strobe_n_out, port_cycle_strobe_n_out, strobe_oe_out;
    logic opcode_fetch_cycle_n_out, opcode_fetch_cycle_n_oe_out;
    logic ext_access_out, ext_read_out, ext_write_out;
    logic [15:0] addr_pin_in, addr_pin_out, ext_addr_out;
    logic [7:0] read_data_out, ext_write_data_out;
    int mismatches = 0, total_checks = 0;
    assign addr_pin_in = addr_pin_oe_out ? addr_pin_out : m_a;
    assign load_strobe_n_in = strobe_oe_out ? load_strobe_n_out : m_rd;
    assign port_cycle_strobe_n_in = strobe_oe_out ? port_cycle_strobe_n_out
        : m_port;
    assign write_strobe_n_in = strobe_oe_out ? write_strobe_n_out : m_wr;
    // the external master drives the data bus only during its own write
    assign data_pin_in = m_wr ? dev_bus : m_d;
    assign memory_cycle_strobe_n_in = strobe_oe_out ?
        memory_cycle_strobe_n_out : 1'b1;
    cpu_bus_pins uut (.*);
    ext_dev dev (.clk_in(clk_in), .oe_in(data_pin_oe_out),
        .rd_n_in(load_strobe_n_in), .mem_n_in(memory_cycle_strobe_n_in),
        .port_n_in(port_cycle_strobe_n_in), .addr_in(addr_pin_in),
        .fetch_n_in(opcode_fetch_cycle_n_out), .dout_in(data_pin_out),
        .bus_out(dev_bus));
    always #25 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // es is {memory, port, read, write, fetch} seen low
    task automatic run(input cycle_kind_t k, input logic [4:0] es,
        input logic [7:0] ed);
        logic [4:0] s;
        logic ok;
        logic [15:0] ea, mk;
        s = 5'h00;
        ok = 1;
        ea = k == cyc_refresh ? {cycle_addr_in[15:8], refresh_addr_in}
            : cycle_addr_in;
        mk = k == cyc_int_ack ? 16'h0000 : es[3] ? 16'h00ff : 16'hffff;
        cycle_kind_in = k;
        cycle_start_in = 1;
        @(posedge clk_in) #1 cycle_start_in = 0;
        for (int n = 0; n < 8 && cycle_done_out !== 1'b1; n++)
        begin
            s |= ~{memory_cycle_strobe_n_out, port_cycle_strobe_n_out,
                load_strobe_n_out, write_strobe_n_out,
                opcode_fetch_cycle_n_out};
            ok &= s == 0 || (((addr_pin_out ^ ea) & mk) == 0);
            if (!write_strobe_n_out || internal_target_in)
                ok &= data_pin_oe_out && data_pin_out === ed;
            @(posedge clk_in) #1;
        end
        chk("done", 16'h1, cycle_done_out);
        chk("strobes", es, s);
        chk("addr and data", 16'h1, ok);
        if (es[2] || k == cyc_int_ack)
            chk("read byte", ed, read_data_out);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #50000 mismatches++;
        stop_test;
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        #1 rst_in = 0;
        @(posedge clk_in) #1;
        // back to back: each start after the first is given while done stands
        run(cyc_fetch, 5'h15, 8'h69);
        run(cyc_mem_read, 5'h14, 8'h69);
        run(cyc_mem_write, 5'h12, 8'ha5);
        run(cyc_port_read, 5'h0c, 8'h69);
        run(cyc_port_write, 5'h0a, 8'ha5);
        run(cyc_int_ack, 5'h09, 8'h3c);
        run(cyc_refresh, 5'h10, 8'h00);
        internal_target_in = 1;
        run(cyc_port_write, 5'h0a, 8'ha5);
        run(cyc_port_read, 5'h0c, 8'h96);
        internal_target_in = 0;
        emulation_mode_in = 1;
        repeat (4) @(posedge clk_in) #1;
        chk("fetch oe", 16'h0, opcode_fetch_cycle_n_oe_out);
        emulation_mode_in = 0;
        ext_master_in = 1;
        m_port = 0;
        m_rd = 0;
        repeat (5) @(posedge clk_in) #1;
        chk("fetch oe back", 16'h1, opcode_fetch_cycle_n_oe_out);
        chk("addr oe", 16'h0, addr_pin_oe_out);
        chk("strobe oe", 16'h0, strobe_oe_out);
        chk("ext addr", 16'h0042, ext_addr_out);
        chk("ext data", 16'h196, {data_pin_oe_out, data_pin_out});
        chk("ext read", 16'h1, ext_read_out);
        m_rd = 1;
        repeat (4) @(posedge clk_in) #1;
        chk("ext release", 16'h0, data_pin_oe_out);
        chk("ext read end", 16'h0, ext_read_out);
        m_wr = 0;
        repeat (3) @(posedge clk_in) #1;
        chk("ext write", 16'h1, ext_write_out);
        chk("ext write data", 16'hc3, ext_write_data_out);
        @(posedge clk_in) #1;
        chk("ext write pulse end", 16'h0, ext_write_out);
        stop_test;
    end
endmodule
